// [pkg/bit_exec_defs.svh]
// Constant definitions for the bit-set and bit-test-skip execution block
`ifndef BIT_EXEC_DEFS_SVH
`define BIT_EXEC_DEFS_SVH
`define INSTR_W        14
`define ADDR_W         7
`define BITPOS_W       3
`define DATA_W         8
`define OPC_HI         13
`define OPC_LO         10
`define BITPOS_HI      9
`define BITPOS_LO      7
`define ADDR_HI        6
`define ADDR_LO        0
`define OPC_BIT_SET    4'h5
`define OPC_TEST_CLR   4'h6
`define PHASE_DIV      2'h0
`define PHASE_LAST     2'h3
`endif

// [pkg/bit_exec_pkg.sv]
// Types shared by the bit-set and bit-test-skip execution block
package bit_exec_pkg;
`include "bit_exec_defs.svh"

   // Instruction-cycle phases, Gray coded along the normal order
   typedef enum logic [1:0]
   {
      phase_one   = 2'h0,
      phase_two   = 2'h1,
      phase_three = 2'h3,
      phase_four  = 2'h2
   } phase_t;

   typedef struct packed
   {
      logic                   rd_en;
      logic [`ADDR_W-1:0]     rd_addr;
   } rf_rd_req_t;

   typedef struct packed
   {
      logic                   wr_en;
      logic [`ADDR_W-1:0]     wr_addr;
      logic [`DATA_W-1:0]     wr_data;
   } rf_wr_req_t;

   typedef struct packed
   {
      logic                   is_set;
      logic                   is_test;
      logic [`BITPOS_W-1:0]   bit_pos;
      logic [`ADDR_W-1:0]     reg_addr;
   } decoded_t;
endpackage : bit_exec_pkg

// [design/phase_seq.sv]
// Four-phase instruction cycle sequencer
`timescale 1ns/10ps
`include "bit_exec_defs.svh"
module phase_seq
   import bit_exec_pkg::*;
(
   input  wire logic            clk_i,
   input  wire logic            rst_b_i,
   output bit_exec_pkg::phase_t phase_o,
   output logic                 cycle_end_o
);
   import bit_exec_pkg::*;

   phase_t next_phase;

   always_comb
   begin
      unique case (phase_o)
         phase_one:   next_phase = phase_two;
         phase_two:   next_phase = phase_three;
         phase_three: next_phase = phase_four;
         phase_four:  next_phase = phase_one;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         phase_o <= phase_one;
      else
         phase_o <= next_phase;
   end

   assign cycle_end_o = (phase_o == phase_four);
endmodule : phase_seq

// [design/instr_decode.sv]
// Operand and opcode decoder for the two bit instructions
`timescale 1ns/10ps
`include "bit_exec_defs.svh"
module instr_decode
   import bit_exec_pkg::*;
(
   input  wire logic [`INSTR_W-1:0] instr_i,
   output bit_exec_pkg::decoded_t   dec_o
);
   import bit_exec_pkg::*;

   wire logic [`OPC_HI-`OPC_LO:0] opc = instr_i[`OPC_HI:`OPC_LO];

   assign dec_o.is_set   = (opc == `OPC_BIT_SET);
   assign dec_o.is_test  = (opc == `OPC_TEST_CLR);
   assign dec_o.bit_pos  = instr_i[`BITPOS_HI:`BITPOS_LO];
   assign dec_o.reg_addr = instr_i[`ADDR_HI:`ADDR_LO];
endmodule : instr_decode

// [design/bit_set_and_test_skip_exec.sv]
// Execution sequencer for the bit-set and bit-test-skip-if-clear instructions
//
// Behaviour
// - Bit set forces one bit, flags untouched
// - Register address seven bits, bit position three
// - Bit set decoded from opcode 01 01
// - Bit set: one cycle, decode read modify write
// - Bit test decoded from opcode 01 10
// - Tested bit one: next instruction runs normally
// - Tested bit zero: next instruction becomes no-operation
// - Test takes one cycle, two when skipping
// - Test reads and evaluates, never writes
// - Skipped cycle: no read, modify or write
`timescale 1ns/10ps
`include "bit_exec_defs.svh"
module bit_set_and_test_skip_exec
   import bit_exec_pkg::*;
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_b_i,
   input  wire logic [`INSTR_W-1:0]  instr_i,
   input  wire logic [`DATA_W-1:0]   rd_data_i,
   output bit_exec_pkg::rf_rd_req_t  rd_req_o,
   output bit_exec_pkg::rf_wr_req_t  wr_req_o,
   output bit_exec_pkg::phase_t      phase_o,
   output logic                      flush_o,
   output logic                      pc_inc_o,
   output logic                      nop_cycle_o
);
   import bit_exec_pkg::*;

   // ************************************************************
   // Phase sequencing and decode
   // ************************************************************
   phase_t    phase;
   logic      cycle_end;
   decoded_t  dec;
   decoded_t  cur;
   logic      squash;
   logic [`DATA_W-1:0] rd_value;
   logic      skip_pending;

   phase_seq u_phase_seq
   (
      .clk_i       (clk_i),
      .rst_b_i     (rst_b_i),
      .phase_o     (phase),
      .cycle_end_o (cycle_end)
   );

   instr_decode u_instr_decode
   (
      .instr_i (instr_i),
      .dec_o   (dec)
   );

   // The instruction word is latched in phase one; a squashed cycle latches a cleared decode
   wire logic take_instr = (phase == phase_one);
   wire logic next_squash_start = take_instr ? skip_pending : squash;

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         cur    <= '0;
         squash <= 1'b0;
      end
      else if (take_instr)
      begin
         squash <= skip_pending;
         cur    <= skip_pending ? decoded_t'('0) : dec;
      end
   end

   // ************************************************************
   // Read, modify, write
   // ************************************************************
   wire logic read_now = (phase == phase_two) && (cur.is_set || cur.is_test) && !squash;
   wire logic [`DATA_W-1:0] bit_mask = `DATA_W'(1) << cur.bit_pos;
   wire logic [`DATA_W-1:0] set_value = rd_value | bit_mask;
   // Read data settles only at the phase_three edge, so the bit is tested in phase_four
   wire logic tested_bit = |(rd_value & bit_mask);
   wire logic eval_skip = (phase == phase_four) && cur.is_test && !squash && !tested_bit;
   wire rf_rd_req_t next_rd_req = {read_now, cur.reg_addr};
   wire rf_wr_req_t next_wr_req = {write_now, cur.reg_addr, set_value};
   wire logic write_now = (phase == phase_four) && cur.is_set && !squash;

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         rd_value <= '0;
      else if (phase == phase_three)
         rd_value <= rd_data_i;
   end

   // Skip decision held until the next fetch boundary, then consumed
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         skip_pending <= 1'b0;
      else if (eval_skip)
         skip_pending <= 1'b1;
      else if (take_instr)
         skip_pending <= 1'b0;
   end

   // ************************************************************
   // Registered outputs
   // ************************************************************
   // One flop per port keeps every output glitch-free for the core
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         phase_o <= phase_one;
      else
         phase_o <= phase;
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         rd_req_o <= '0;
      else
         rd_req_o <= next_rd_req;
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         wr_req_o <= '0;
      else
         wr_req_o <= next_wr_req;
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         flush_o <= 1'b0;
      else
         flush_o <= eval_skip;
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         pc_inc_o <= 1'b0;
      else
         pc_inc_o <= cycle_end;
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         nop_cycle_o <= 1'b0;
      else
         nop_cycle_o <= next_squash_start;
   end

   // ************************************************************
   // Checks
   // ************************************************************
   sequence s_test_clear;
      (phase == phase_four) && cur.is_test && !squash && !tested_bit;
   endsequence

   property p_set_opcode;
      @(posedge clk_i) disable iff (!rst_b_i)
         (phase == phase_one && instr_i[`OPC_HI:`OPC_LO] == `OPC_BIT_SET && !skip_pending)
         |=> cur.is_set && cur.reg_addr == $past(instr_i[`ADDR_HI:`ADDR_LO]);
   endproperty
   a_set_opcode: assert property (p_set_opcode) else $error("bit set not decoded");

   property p_test_opcode;
      @(posedge clk_i) disable iff (!rst_b_i)
         (phase == phase_one && instr_i[`OPC_HI:`OPC_LO] == `OPC_TEST_CLR && !skip_pending)
         |=> cur.is_test && cur.bit_pos == $past(instr_i[`BITPOS_HI:`BITPOS_LO]);
   endproperty
   a_test_opcode: assert property (p_test_opcode) else $error("bit test not decoded");

   property p_set_write;
      @(posedge clk_i) disable iff (!rst_b_i)
         write_now |=> wr_req_o.wr_en && wr_req_o.wr_data == ($past(rd_value) | $past(bit_mask));
   endproperty
   a_set_write: assert property (p_set_write) else $error("bit set write wrong");

   property p_set_rmw;
      @(posedge clk_i) disable iff (!rst_b_i)
         read_now && cur.is_set |=> ##2 wr_req_o.wr_en;
   endproperty
   a_set_rmw: assert property (p_set_rmw) else $error("read not followed by write");

   property p_test_no_write;
      @(posedge clk_i) disable iff (!rst_b_i)
         (phase == phase_four && cur.is_test) |=> !wr_req_o.wr_en;
   endproperty
   a_test_no_write: assert property (p_test_no_write) else $error("test wrote");

   property p_skip_flush;
      @(posedge clk_i) disable iff (!rst_b_i)
         s_test_clear |=> flush_o ##2 squash;
   endproperty
   a_skip_flush: assert property (p_skip_flush) else $error("skip not taken");

   property p_no_skip_on_one;
      @(posedge clk_i) disable iff (!rst_b_i)
         (phase == phase_four && cur.is_test && !squash && tested_bit) |=> ##2 !squash;
   endproperty
   a_no_skip_on_one: assert property (p_no_skip_on_one) else $error("bad skip");

   property p_squash_quiet;
      @(posedge clk_i) disable iff (!rst_b_i)
         squash |-> !read_now && !write_now && !eval_skip;
   endproperty
   a_squash_quiet: assert property (p_squash_quiet) else $error("squashed cycle active");

   property p_squash_len;
      @(posedge clk_i) disable iff (!rst_b_i)
         $rose(squash) |-> squash [*4] ##1 !squash;
   endproperty
   a_squash_len: assert property (p_squash_len) else $error("skip not one cycle");

   property p_pc_advance;
      @(posedge clk_i) disable iff (!rst_b_i)
         (phase == phase_four && squash) |=> pc_inc_o;
   endproperty
   a_pc_advance: assert property (p_pc_advance) else $error("pc held on skip");

   // ************************************************************
   // Port-level sequence checks
   // ************************************************************
   sequence s_set_taken;
      (phase == phase_one) && (instr_i[`OPC_HI:`OPC_LO] == `OPC_BIT_SET) && !skip_pending;
   endsequence

   sequence s_set_steps;
      !rd_req_o.rd_en ##1 rd_req_o.rd_en ##1 !rd_req_o.rd_en ##1 wr_req_o.wr_en;
   endsequence

   sequence s_test_one;
      (phase == phase_four) && cur.is_test && !squash && tested_bit;
   endsequence

   sequence s_skip_window;
      !nop_cycle_o ##1 nop_cycle_o [*4] ##1 !nop_cycle_o;
   endsequence

   property p_set_steps;
      @(posedge clk_i) disable iff (!rst_b_i)
         s_set_taken |=> s_set_steps;
   endproperty
   a_set_steps: assert property (p_set_steps) else $error("bit set phases wrong");

   property p_skip_nop_len;
      @(posedge clk_i) disable iff (!rst_b_i)
         s_test_clear |=> s_skip_window;
   endproperty
   a_skip_nop_len: assert property (p_skip_nop_len) else $error("no-op cycle wrong");

   property p_one_no_flush;
      @(posedge clk_i) disable iff (!rst_b_i)
         s_test_one |=> !flush_o ##1 !nop_cycle_o;
   endproperty
   a_one_no_flush: assert property (p_one_no_flush) else $error("skip on set bit");

   property p_skip_no_access;
      @(posedge clk_i) disable iff (!rst_b_i)
         $rose(squash) |-> (!rd_req_o.rd_en && !wr_req_o.wr_en) [*4];
   endproperty
   a_skip_no_access: assert property (p_skip_no_access) else $error("skipped access");

   property p_skip_no_write;
      @(posedge clk_i) disable iff (!rst_b_i)
         s_test_clear |=> ##4 !wr_req_o.wr_en;
   endproperty
   a_skip_no_write: assert property (p_skip_no_write) else $error("skipped word wrote");

   property p_read_addr;
      @(posedge clk_i) disable iff (!rst_b_i)
         rd_req_o.rd_en |-> rd_req_o.rd_addr == $past(instr_i[`ADDR_HI:`ADDR_LO], 2);
   endproperty
   a_read_addr: assert property (p_read_addr) else $error("read address wrong");

   property p_write_addr;
      @(posedge clk_i) disable iff (!rst_b_i)
         wr_req_o.wr_en |-> wr_req_o.wr_addr == $past(instr_i[`ADDR_HI:`ADDR_LO], 4);
   endproperty
   a_write_addr: assert property (p_write_addr) else $error("write address wrong");

   property p_write_bit;
      @(posedge clk_i) disable iff (!rst_b_i)
         wr_req_o.wr_en |-> wr_req_o.wr_data[$past(instr_i[`BITPOS_HI:`BITPOS_LO], 4)];
   endproperty
   a_write_bit: assert property (p_write_bit) else $error("selected bit not set");

   property p_flush_pulse;
      @(posedge clk_i) disable iff (!rst_b_i)
         flush_o |=> !flush_o;
   endproperty
   a_flush_pulse: assert property (p_flush_pulse) else $error("flush too long");

   property p_pc_period;
      @(posedge clk_i) disable iff (!rst_b_i)
         pc_inc_o |=> !pc_inc_o [*3] ##1 pc_inc_o;
   endproperty
   a_pc_period: assert property (p_pc_period) else $error("pc step not per cycle");

   property p_other_ignored;
      @(posedge clk_i) disable iff (!rst_b_i)
         (phase == phase_one && instr_i[`OPC_HI:`OPC_LO] != `OPC_BIT_SET
            && instr_i[`OPC_HI:`OPC_LO] != `OPC_TEST_CLR) |=> !cur.is_set && !cur.is_test;
   endproperty
   a_other_ignored: assert property (p_other_ignored) else $error("foreign opcode run");

   property p_phase_wrap;
      @(posedge clk_i) disable iff (!rst_b_i)
         (phase_o == phase_four) |=> (phase_o == phase_one);
   endproperty
   a_phase_wrap: assert property (p_phase_wrap) else $error("phase order wrong");
endmodule : bit_set_and_test_skip_exec

// [tb/reg_file_model.sv]
// Register file model facing the bit execution block
`timescale 1ns/10ps
`include "bit_exec_defs.svh"
module reg_file_model
   import bit_exec_pkg::*;
(
   input  wire logic                 clk_i,
   input  bit_exec_pkg::rf_rd_req_t  rd_req_i,
   input  bit_exec_pkg::rf_wr_req_t  wr_req_i,
   output logic [`DATA_W-1:0]        rd_data_o
);
   logic [`DATA_W-1:0] mem [0:127];
   logic [`DATA_W-1:0] last;
   initial
   begin
      for (int i = 0; i < 128; i++)
         mem[i] = 8'((i * 59) ^ 165);
      last = 8'h00;
   end
   // Outside a read the bus shows the inverse, so a late sample is caught
   assign rd_data_o = rd_req_i.rd_en ? mem[rd_req_i.rd_addr] : ~last;
   always @(posedge clk_i)
   begin
      if (rd_req_i.rd_en)
         last <= mem[rd_req_i.rd_addr];
      if (wr_req_i.wr_en)
         mem[wr_req_i.wr_addr] <= wr_req_i.wr_data;
   end
endmodule : reg_file_model

// [tb/bit_set_and_test_skip_exec_tb_top.sv]
// Self-checking bench for the bit-set and bit-test-skip execution block
`timescale 1ns/10ps
`include "bit_exec_defs.svh"
module bit_set_and_test_skip_exec_tb_top;
   import bit_exec_pkg::*;
   logic                clk_i;
   logic                rst_b_i;
   logic [`INSTR_W-1:0] instr_i;
   logic [`DATA_W-1:0]  rd_data_i;
   rf_rd_req_t          rd_req_o;
   rf_wr_req_t          wr_req_o;
   phase_t              phase_o;
   logic                flush_o, pc_inc_o, nop_cycle_o, nop_q;
   int                  fails, checked, cycles, seed, skip_pend, skips;
   int                  n_cyc, n_pc, n_fl, n_nop, r;
   int                  ref_mem [128];
   int                  exp_rd [$];
   int                  exp_wr [$];

   bit_set_and_test_skip_exec DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .instr_i(instr_i),
      .rd_data_i(rd_data_i), .rd_req_o(rd_req_o), .wr_req_o(wr_req_o), .phase_o(phase_o),
      .flush_o(flush_o), .pc_inc_o(pc_inc_o), .nop_cycle_o(nop_cycle_o));
   reg_file_model partner (.clk_i(clk_i), .rd_req_i(rd_req_o), .wr_req_i(wr_req_o),
      .rd_data_o(rd_data_i));

   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   task chk(input logic [31:0] seen, input logic [31:0] expv);
      checked++;
      if (seen !== expv)
      begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask : chk

   task print_verdict();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict

   // Called at a falling edge; the word is taken at the next phase_one edge
   task issue(input logic [3:0] op, input logic [2:0] b, input logic [6:0] a);
      if (n_cyc > 0)
         chk(phase_o, phase_four);
      instr_i = {op, b, a};
      n_cyc++;
      if (skip_pend != 0)
         skip_pend = 0;
      else if (op == 4'h5)
      begin
         exp_rd.push_back(a);
         ref_mem[a] = ref_mem[a] | (1 << b);
         exp_wr.push_back(a * 256 + ref_mem[a]);
      end
      else if (op == 4'h6)
      begin
         exp_rd.push_back(a);
         if (((ref_mem[a] >> b) & 1) == 0)
         begin
            skip_pend = 1;
            skips++;
         end
      end
      repeat (4) @(negedge clk_i);
   endtask : issue

   // Every read and write the block makes must match the model, in order
   always @(negedge clk_i)
   begin
      if (rst_b_i)
      begin
         cycles++;
         if (cycles > 5000)
         begin
            fails++;
            print_verdict();
         end
         if (rd_req_o.rd_en)
            chk(rd_req_o.rd_addr, exp_rd.size() ? exp_rd.pop_front() : -1);
         if (wr_req_o.wr_en)
            chk(wr_req_o[14:0], exp_wr.size() ? exp_wr.pop_front() : -1);
         n_pc += pc_inc_o;
         n_fl += flush_o;
         n_nop += (nop_cycle_o && !nop_q);
         nop_q = nop_cycle_o;
      end
   end

   initial
   begin
      rst_b_i = 1'b0;
      instr_i = 14'h0000;
      nop_q = 1'b0;
      seed = 32'h590F485A;
      for (int i = 0; i < 128; i++)
         ref_mem[i] = ((i * 59) ^ 165) & 255;
      repeat (16) @(negedge clk_i);
      rst_b_i = 1'b1;
      // Boundary address; a squashed set must leave no trace
      issue(4'h5, 3'h0, 7'h7F);
      issue(4'h6, 3'h0, 7'h7F);
      issue(4'h6, 3'h4, 7'h7F);
      issue(4'h5, 3'h4, 7'h7F);
      issue(4'h6, 3'h4, 7'h7F);
      issue(4'h6, 3'h4, 7'h7F);
      issue(4'h5, 3'h7, 7'h00);
      issue(4'h0, 3'h0, 7'h00);
      $display("directed test done");
      for (int k = 0; k < 300; k++)
      begin
         r = $random(seed);
         issue(r[1:0] == 2'h0 ? 4'(r >> 8) : (r[0] ? 4'h5 : 4'h6), 3'(r >> 12), 7'(r >> 16));
      end
      issue(4'h0, 3'h0, 7'h00);
      issue(4'h0, 3'h0, 7'h00);
      $display("random test done");
      chk(n_fl, skips);
      chk(n_nop, skips);
      chk(n_pc >= n_cyc - 1 && n_pc <= n_cyc, 1);
      chk(exp_rd.size() + exp_wr.size(), 0);
      print_verdict();
   end
endmodule : bit_set_and_test_skip_exec_tb_top
